// *** design/lfs_fault_supervisor.sv ***
// Fault supervisor: gates the high-side switch and drives the fault pin.
// Assumes comparator levels synchronous to ref_clk and a host pull-up on the fault pin.
`timescale 1ns/1ns
module lfs_fault_supervisor #(
  parameter int RETRY_CYCLES_P = lfs_pkg::RETRY_CYCLES,     // 1ms retry wait
  parameter int PERSIST_CYCLES_P = lfs_pkg::PERSIST_CYCLES  // 10ms persistence window
) (
  input wire logic ref_clk,                 // 20 MHz clock
  input wire logic reset_n,                 // Power-on reset, active low
  input wire logic overcurrentTrip,         // Switch current above limit
  input wire logic feedbackSenseOver,       // Feedback above 2V
  input wire logic feedbackSenseRecovered,  // Feedback below 1.55V
  input wire logic feedbackSenseAvgLow,     // Feedback average below 0.2V
  input wire logic outputVoltLow,           // Filtered output below 1V
  input wire logic enablePwm,               // Enable / PWM dimming input
  output logic highSideOn,                  // High-side gate command
  output logic stringOff,                   // String shut off by open/short fault
  output logic faultReportLowOut,           // Fault pin output value, always low
  output logic faultReportLowOe             // Fault pin pull-down enable
);
  import lfs_pkg::*;

  localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYCLES_P - 1);
  localparam logic [CNT_W-1:0] PERSIST_LAST = CNT_W'(PERSIST_CYCLES_P - 1);
  localparam logic [DEG_W-1:0] DEG_LAST = DEG_W'(DEGLITCH_CYCLES - 1);
  localparam logic [PWM_W-1:0] PWM_LAST = PWM_W'(PWM_CYCLES - 1);

  lfs_sw_t swState_reg;
  logic [CNT_W-1:0] retryCnt_reg;
  logic ocpSeen_reg;
  logic ocpFault_reg;
  logic [CNT_W-1:0] ocpQuietCnt_reg;
  logic ovpFault_reg;
  logic [CNT_W-1:0] ovpClrCnt_reg;
  logic enPrev_reg;
  logic pwmMode_reg;
  logic [CNT_W-1:0] enHighCnt_reg;
  logic [STR_NUM-1:0] strFault_reg;
  logic [CNT_W-1:0] persistCnt_reg [STR_NUM];
  logic [DEG_W-1:0] deglitchCnt_reg [STR_NUM];
  logic [PWM_W-1:0] pwmCnt_reg [STR_NUM];

  logic tripNow;
  logic enRise;
  logic enFall;
  logic [STR_NUM-1:0] strCond;

  // Input decode shared by the sequencer and the detectors
  assign tripNow = overcurrentTrip | feedbackSenseOver;
  assign enRise = enablePwm & ~enPrev_reg;                   // [RULE14]
  assign enFall = ~enablePwm & enPrev_reg;
  assign strCond[STR_OPEN] = feedbackSenseAvgLow;
  assign strCond[STR_SHORT] = outputVoltLow;

  // Gate is killed combinationally so a trip needs no clock edge to act
  assign highSideOn = (swState_reg == SW_RUN) & ~tripNow & enablePwm & ~stringOff; // [RULE1] [RULE4]
  assign stringOff = |strFault_reg;                          // [RULE6] [RULE9]
  // Open-drain pin: only ever pulls low, released while nothing is latched and feedback is not over
  assign faultReportLowOut = 1'b0;                           // [RULE13]
  assign faultReportLowOe = ocpFault_reg | ovpFault_reg | feedbackSenseOver
                            | stringOff;                     // [RULE13] [RULE4]

  // Switch sequencer: off on any trip, back on after the retry wait
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      swState_reg <= SW_RUN;
      retryCnt_reg <= CNT_RST;
    end else begin
      unique case (swState_reg)
        SW_RUN: begin
          retryCnt_reg <= CNT_RST;
          if (tripNow) begin
            swState_reg <= SW_RETRY;                         // [RULE1] [RULE4]
          end
        end
        SW_RETRY: begin
          if (tripNow) begin
            retryCnt_reg <= CNT_RST;                         // A lingering trip restarts the wait
          end else if (retryCnt_reg == RETRY_LAST) begin
            swState_reg <= SW_RUN;                           // [RULE1]
            retryCnt_reg <= CNT_RST;
          end else begin
            retryCnt_reg <= retryCnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // Overcurrent class: report on second trip, release after a quiet 10ms
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ocpSeen_reg <= FAULT_RST;
      ocpFault_reg <= FAULT_RST;
      ocpQuietCnt_reg <= CNT_RST;
    end else if (overcurrentTrip) begin
      ocpSeen_reg <= 1'b1;
      ocpQuietCnt_reg <= CNT_RST;                            // [RULE14]
      if (ocpSeen_reg) begin
        ocpFault_reg <= 1'b1;                                // [RULE2]
      end
    end else if (ocpSeen_reg) begin
      if (ocpQuietCnt_reg == PERSIST_LAST) begin
        ocpSeen_reg <= 1'b0;                                 // [RULE3]
        ocpFault_reg <= 1'b0;
        ocpQuietCnt_reg <= CNT_RST;
      end else begin
        ocpQuietCnt_reg <= ocpQuietCnt_reg + 1'b1;
      end
    end
  end

  // Feedback over-voltage: latched at once, cleared after 10ms below recovery level
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovpFault_reg <= FAULT_RST;
      ovpClrCnt_reg <= CNT_RST;
    end else if (feedbackSenseOver) begin
      ovpFault_reg <= 1'b1;                                  // [RULE4]
      ovpClrCnt_reg <= CNT_RST;
    end else if (ovpFault_reg && feedbackSenseRecovered) begin
      if (ovpClrCnt_reg == PERSIST_LAST) begin
        ovpFault_reg <= 1'b0;                                // [RULE5]
        ovpClrCnt_reg <= CNT_RST;
      end else begin
        ovpClrCnt_reg <= ovpClrCnt_reg + 1'b1;
      end
    end else begin
      ovpClrCnt_reg <= CNT_RST;                              // [RULE14]
    end
  end

  // Dimming detect: a low pulse on enable selects cycle counting,
  // 10ms of steady high returns to time-based filtering
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      enPrev_reg <= 1'b0;
      pwmMode_reg <= PWM_MODE_RST;
      enHighCnt_reg <= CNT_RST;
    end else begin
      enPrev_reg <= enablePwm;
      if (!enablePwm) begin
        enHighCnt_reg <= CNT_RST;
        if (enFall) begin
          pwmMode_reg <= 1'b1;                               // [RULE12]
        end
      end else if (enHighCnt_reg == PERSIST_LAST) begin
        pwmMode_reg <= 1'b0;                                 // [RULE12]
      end else begin
        enHighCnt_reg <= enHighCnt_reg + 1'b1;
      end
    end
  end

  // Open and short detectors share one structure; the persistence counter
  // times detection while clear without dimming, and recovery while latched
  for (genvar i = 0; i < STR_NUM; i++) begin : g_str
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        strFault_reg[i] <= FAULT_RST;
        persistCnt_reg[i] <= CNT_RST;
        deglitchCnt_reg[i] <= DEG_RST;
        pwmCnt_reg[i] <= PWM_RST;
      end else if (!strFault_reg[i]) begin
        if (!strCond[i]) begin
          persistCnt_reg[i] <= CNT_RST;                      // [RULE14]
          deglitchCnt_reg[i] <= DEG_RST;
          pwmCnt_reg[i] <= PWM_RST;
        end else if (pwmMode_reg) begin
          persistCnt_reg[i] <= CNT_RST;
          if (deglitchCnt_reg[i] != DEG_LAST) begin
            deglitchCnt_reg[i] <= deglitchCnt_reg[i] + 1'b1; // [RULE7] [RULE10]
          end else if (enRise) begin
            if (pwmCnt_reg[i] == PWM_LAST) begin
              strFault_reg[i] <= 1'b1;                       // [RULE7] [RULE10]
              pwmCnt_reg[i] <= PWM_RST;
            end else begin
              pwmCnt_reg[i] <= pwmCnt_reg[i] + 1'b1;         // [RULE14]
            end
          end
        end else begin
          deglitchCnt_reg[i] <= DEG_RST;
          pwmCnt_reg[i] <= PWM_RST;
          if (persistCnt_reg[i] == PERSIST_LAST) begin
            strFault_reg[i] <= 1'b1;                         // [RULE6] [RULE9]
            persistCnt_reg[i] <= CNT_RST;
          end else begin
            persistCnt_reg[i] <= persistCnt_reg[i] + 1'b1;
          end
        end
      end else begin
        deglitchCnt_reg[i] <= DEG_RST;
        pwmCnt_reg[i] <= PWM_RST;
        if (strCond[i]) begin
          persistCnt_reg[i] <= CNT_RST;                      // [RULE14]
        end else if (persistCnt_reg[i] == PERSIST_LAST) begin
          strFault_reg[i] <= 1'b0;                           // [RULE8] [RULE11]
          persistCnt_reg[i] <= CNT_RST;
        end else begin
          persistCnt_reg[i] <= persistCnt_reg[i] + 1'b1;
        end
      end
    end

    // Detection and recovery timing and pin report per string detector
    chk_str_timed_set: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE6] [RULE9]
      $rose(strFault_reg[i]) && !$past(pwmMode_reg) |-> $past(persistCnt_reg[i]) == PERSIST_LAST)
      else $error("string fault set before the 10ms window");
    chk_str_pwm_set: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE7] [RULE10]
      $rose(strFault_reg[i]) && $past(pwmMode_reg) |->
        $past(pwmCnt_reg[i]) == PWM_LAST && $past(deglitchCnt_reg[i]) == DEG_LAST && $past(enRise))
      else $error("string fault set before 128 PWM cycles");
    chk_str_recover: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE8] [RULE11]
      $fell(strFault_reg[i]) |-> $past(persistCnt_reg[i]) == PERSIST_LAST && !$past(strCond[i]))
      else $error("string fault cleared early");
    chk_str_restart: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE14]
      !strFault_reg[i] && !strCond[i] |=> persistCnt_reg[i] == CNT_RST && pwmCnt_reg[i] == PWM_RST)
      else $error("detection timer did not restart");
    // A latched fault restarts its recovery window whenever the condition returns
    chk_str_latched_restart: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE14]
      strFault_reg[i] && strCond[i] |=> persistCnt_reg[i] == CNT_RST)
      else $error("recovery timer did not restart");
    // No PWM cycle may be counted before the deglitch time has run out
    chk_str_deglitch_first: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE7] [RULE10]
      !strFault_reg[i] && deglitchCnt_reg[i] != DEG_LAST |=> pwmCnt_reg[i] == PWM_RST)
      else $error("PWM cycles counted during deglitch");
    // Every latched string fault holds the pin low
    chk_str_pin_low: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE6] [RULE9]
      strFault_reg[i] |-> faultReportLowOe)
      else $error("string fault not reported on the pin");
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_trip_gate_off: assert property (tripNow |-> !highSideOn) // [RULE1] [RULE4]
    else $error("gate on during a trip");
  chk_retry_wait: assert property ($fell(swState_reg == SW_RETRY) |-> // [RULE1]
    $past(retryCnt_reg) == RETRY_LAST)
    else $error("retry before the 1ms wait");
  chk_first_trip_quiet: assert property ( // [RULE2]
    overcurrentTrip && !ocpSeen_reg && !ocpFault_reg |=> !ocpFault_reg && ocpSeen_reg)
    else $error("fault reported on first overcurrent trip");
  chk_second_trip_report: assert property (overcurrentTrip && ocpSeen_reg |=> // [RULE2]
    ocpFault_reg && faultReportLowOe)
    else $error("second overcurrent trip not reported");
  chk_ocp_release: assert property ($fell(ocpFault_reg) |-> // [RULE3]
    $past(ocpQuietCnt_reg) == PERSIST_LAST && !$past(overcurrentTrip))
    else $error("overcurrent fault released early");
  chk_ovp_immediate: assert property (feedbackSenseOver |-> faultReportLowOe ##1 ovpFault_reg) // [RULE4]
    else $error("over-voltage not reported at once");
  chk_ovp_release: assert property ($fell(ovpFault_reg) |-> // [RULE5]
    $past(ovpClrCnt_reg) == PERSIST_LAST && $past(feedbackSenseRecovered))
    else $error("over-voltage cleared early");
  chk_pin_open_drain: assert property (!faultReportLowOut && // [RULE13]
    (faultReportLowOe == (ocpFault_reg | ovpFault_reg | feedbackSenseOver | stringOff)))
    else $error("fault pin drive inconsistent with latched faults");

  // Gate and pin side effects, timer restarts, fault holds and dimming mode entry and exit
  chk_gate_needs_enable: assert property (!enablePwm |-> !highSideOn) // [RULE12]
    else $error("gate on while enable is low");
  // A latched string fault keeps the string dark and the pin low
  chk_string_gate_off: assert property (stringOff |-> !highSideOn && faultReportLowOe) // [RULE6]
    else $error("string fault did not turn the string off");
  // The gate stays off for the whole retry wait
  chk_retry_gate_off: assert property (swState_reg == SW_RETRY |-> !highSideOn) // [RULE1]
    else $error("gate on during the retry wait");
  // Any trip restarts the retry wait from zero
  chk_retry_restart: assert property (tripNow |=> retryCnt_reg == CNT_RST) // [RULE14]
    else $error("retry wait did not restart");
  // Any overcurrent trip restarts the quiet window
  chk_ocp_quiet_restart: assert property (overcurrentTrip |=> ocpQuietCnt_reg == CNT_RST) // [RULE14]
    else $error("quiet window did not restart");
  // A trip while reported never clears the report
  chk_ocp_hold: assert property (ocpFault_reg && overcurrentTrip |=> ocpFault_reg) // [RULE2]
    else $error("overcurrent report dropped during a trip");
  // Feedback above the recovery level holds the fault and restarts its window
  chk_ovp_hold: assert property ( // [RULE5]
    ovpFault_reg && !feedbackSenseRecovered && !feedbackSenseOver |=>
    ovpFault_reg && ovpClrCnt_reg == CNT_RST)
    else $error("over-voltage recovery window did not restart");
  // Nothing latched and no feedback over-voltage means the pin is released
  chk_released_idle: assert property ( // [RULE13]
    !ocpFault_reg && !ovpFault_reg && !feedbackSenseOver && !stringOff |-> !faultReportLowOe)
    else $error("fault pin pulled low with nothing latched");
  // A falling enable edge selects cycle-counted filtering
  chk_pwm_enter: assert property (enFall |=> pwmMode_reg) // [RULE12]
    else $error("dimming not detected on an enable fall");
  // A long steady high enable returns to time-based filtering
  chk_pwm_leave: assert property ( // [RULE12]
    pwmMode_reg && enablePwm && enHighCnt_reg == PERSIST_LAST |=> !pwmMode_reg)
    else $error("dimming mode not left after steady enable");

  // Main scenarios
  cov_ocp_report: cover property (overcurrentTrip ##1 !overcurrentTrip [*3] ##1 overcurrentTrip);
  cov_ovp_recover: cover property ($fell(ovpFault_reg));
  cov_open_pwm: cover property (pwmMode_reg && $rose(strFault_reg[STR_OPEN]));
  cov_short_timed: cover property (!pwmMode_reg && $rose(strFault_reg[STR_SHORT]));
  cov_retry_done: cover property ($fell(swState_reg == SW_RETRY));
endmodule

// *** design/lfs_pkg.sv ***
// Constants, timing counts and types for the LED driver fault supervisor.
// Assumes a single free-running 20 MHz clock and a power-on reset.
// What this block does
// [RULE1] Overcurrent trip switches the high-side gate off at once; retry after 1ms.
// [RULE2] Overcurrent faults pull the fault pin low only on the second trip.
// [RULE3] Overcurrent fault releases the fault pin after 10ms with no further trip.
// [RULE4] Feedback above 2V: gate off and fault pin low at once, retry after 1ms.
// [RULE5] Over-voltage clears after feedback stays below 1.55V for 10ms.
// [RULE6] No dimming: feedback average below 0.2V for 10ms declares an open string.
// [RULE7] Dimming: low feedback passes 25us deglitch, then 128 PWM cycles, then open.
// [RULE8] Open fault clears after feedback is back at regulation for 10ms.
// [RULE9] No dimming: output below 1V for 10ms declares a shorted string.
// [RULE10] Dimming: low output passes 25us deglitch, then 128 PWM cycles, then short.
// [RULE11] Short fault clears after output stays above 1V for 10ms.
// [RULE12] Host selects dimming by driving a pulse train on the enable input.
// [RULE13] Fault pin is active-low open-drain, released while no fault is latched and feedback is not above 2V.
// [RULE14] Timers restart when their condition drops; PWM cycles counted on enable rises.
package lfs_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RETRY_TIME_US = 1000;
  localparam int PERSIST_TIME_US = 10000;
  localparam int DEGLITCH_TIME_NS = 25000;
  // Least times round up to whole clock cycles
  localparam int RETRY_CYCLES = (RETRY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERSIST_CYCLES = (PERSIST_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEGLITCH_CYCLES = (DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWM_CYCLES = 128;
  // Counter widths
  localparam int CNT_W = 18;
  localparam int DEG_W = 9;
  localparam int PWM_W = 8;
  // String detector indices
  localparam int STR_OPEN = 0;
  localparam int STR_SHORT = 1;
  localparam int STR_NUM = 2;
  // Reset values
  localparam logic FAULT_RST = 1'b0;
  localparam logic PWM_MODE_RST = 1'b0;
  localparam logic [CNT_W-1:0] CNT_RST = 18'h00000;
  localparam logic [DEG_W-1:0] DEG_RST = 9'h000;
  localparam logic [PWM_W-1:0] PWM_RST = 8'h00;
  // High-side switch sequencing
  typedef enum logic {SW_RUN, SW_RETRY} lfs_sw_t;
endpackage

// *** sim/led_driver_fault_supervisor_tb.sv ***
// Self-checking bench for the fault supervisor with short retry and persistence counts.
// Assumes the host model for the fault pin and enable, and inputs driven at the falling edge.
`timescale 1ns/1ns
module led_driver_fault_supervisor_tb;
  import lfs_pkg::*;
  localparam int RETRY = 20;
  localparam int PERSIST = 50;
  logic ref_clk, reset_n, overcurrentTrip, feedbackSenseOver, feedbackSenseRecovered;
  logic feedbackSenseAvgLow, outputVoltLow, enablePwm, highSideOn, stringOff;
  logic faultReportLowOut, faultReportLowOe, pwmRun, faultSeen;
  int badCount, compares;

  lfs_fault_supervisor #(.RETRY_CYCLES_P(RETRY), .PERSIST_CYCLES_P(PERSIST)) i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .overcurrentTrip(overcurrentTrip),
    .feedbackSenseOver(feedbackSenseOver), .feedbackSenseRecovered(feedbackSenseRecovered),
    .feedbackSenseAvgLow(feedbackSenseAvgLow), .outputVoltLow(outputVoltLow),
    .enablePwm(enablePwm), .highSideOn(highSideOn), .stringOff(stringOff),
    .faultReportLowOut(faultReportLowOut), .faultReportLowOe(faultReportLowOe));
  lfs_host_model i_host (.ref_clk(ref_clk), .faultReportLowOut(faultReportLowOut),
    .faultReportLowOe(faultReportLowOe), .pwmRun(pwmRun), .pwmPeriod(8'h08),
    .enablePwm(enablePwm), .faultSeen(faultSeen));

  // 50 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Signal picker so one wait task serves every output: 0 pin, 1 gate, 2 string off
  function automatic logic sig(input int s);
    return (s == 0) ? faultSeen : (s == 1) ? highSideOn : stringOff;
  endfunction

  task automatic check(input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t seen %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Not yet v after lo edges, then v within hi edges; a used-up bound ends the run
  task automatic waitFor(input int s, input logic v, input int lo, input int hi);
    int n;
    n = lo;
    tick(lo);
    #1 check(sig(s), ~v);
    while (sig(s) !== v && n < hi) begin
      tick(1);
      #1 n++;
    end
    check(sig(s), v);
    if (sig(s) !== v) report_and_stop();
  endtask

  task automatic setCond(input int i, input logic v);
    if (i == 0) feedbackSenseAvgLow = v;
    else outputVoltLow = v;
  endtask

  initial begin
    {overcurrentTrip, feedbackSenseOver, feedbackSenseAvgLow, outputVoltLow, pwmRun} = '0;
    feedbackSenseRecovered = 1'b1;
    reset_n = 1'b0;
    badCount = 0;
    compares = 0;
    void'($urandom(55032));
    tick(5);
    reset_n = 1'b1;
    #1 check(faultSeen, 1'b1);
    // Overcurrent: first trip only gates, second trip reports
    tick(1 + $urandom % 5);
    overcurrentTrip = 1'b1;
    #1 check(highSideOn, 1'b0);
    tick(1);
    overcurrentTrip = 1'b0;
    waitFor(1, 1'b1, RETRY - 1, RETRY + 3);
    check(faultSeen, 1'b1);
    overcurrentTrip = 1'b1;
    tick(1);
    overcurrentTrip = 1'b0;
    #1 check(faultSeen, 1'b0);
    waitFor(0, 1'b1, PERSIST - 2, PERSIST + 3);
    $display("test overcurrent done");
    // Feedback over-voltage: pin low at once, released after recovery window
    tick(1 + $urandom % 5);
    feedbackSenseOver = 1'b1;
    feedbackSenseRecovered = 1'b0;
    #1 check(faultSeen, 1'b0);
    check(highSideOn, 1'b0);
    tick(3);
    feedbackSenseOver = 1'b0;
    feedbackSenseRecovered = 1'b1;
    // Gate returns after the retry wait while the pin is still held low
    waitFor(1, 1'b1, RETRY - 1, RETRY + 3);
    check(faultSeen, 1'b0);
    waitFor(0, 1'b1, PERSIST - RETRY - 2, PERSIST - RETRY + 3);
    $display("test overvoltage done");
    // Open then short string, steady enable, with a dropout that restarts the window
    for (int i = 0; i < 2; i++) begin
      tick(1);
      setCond(i, 1'b1);
      tick(10 + $urandom % 30);
      setCond(i, 1'b0);
      tick(1);
      setCond(i, 1'b1);
      waitFor(0, 1'b0, PERSIST - 1, PERSIST + 2);
      check(stringOff, 1'b1);
      check(highSideOn, 1'b0);
      setCond(i, 1'b0);
      waitFor(0, 1'b1, PERSIST - 1, PERSIST + 2);
      check(stringOff, 1'b0);
    end
    $display("test string steady done");
    // Dimming: deglitch, then 128 enable rises at 8 cycles each before the fault
    pwmRun = 1'b1;
    for (int i = 0; i < 2; i++) begin
      tick(4 + $urandom % 8);
      setCond(i, 1'b1);
      waitFor(0, 1'b0, DEGLITCH_CYCLES + 960, DEGLITCH_CYCLES + 1100);
      setCond(i, 1'b0);
      waitFor(0, 1'b1, PERSIST - 1, PERSIST + 2);
    end
    pwmRun = 1'b0;
    $display("test string dimming done");
    report_and_stop();
  end
endmodule

// *** sim/lfs_host_model.sv ***
// Host-side model: pull-up on the fault pin and the enable / dimming driver.
// Assumes the supervisor only pulls the pin low and that the bench sets the dimming period.
`timescale 1ns/1ns
module lfs_host_model (
  input wire logic ref_clk,            // Shared 20 MHz clock
  input wire logic faultReportLowOut,  // Pin data from the supervisor
  input wire logic faultReportLowOe,   // Pin pull-down enable
  input wire logic pwmRun,             // Request for a dimming pulse train
  input wire logic [7:0] pwmPeriod,    // Dimming period in clock cycles
  output logic enablePwm,              // Enable pin as the host drives it
  output logic faultSeen               // Pin level as the host reads it
);
  logic [7:0] phaseCnt;

  // Pull-up: pin reads high unless pulled down, so a released pin never shows old data
  assign faultSeen = faultReportLowOe ? faultReportLowOut : 1'b1;

  // Enable is steady high, or a half-duty pulse train while dimming is asked for
  initial begin
    enablePwm = 1'b1;
    phaseCnt = 8'h00;
  end
  always @(negedge ref_clk) begin
    if (pwmRun) begin
      phaseCnt <= (phaseCnt + 8'h01 >= pwmPeriod) ? 8'h00 : phaseCnt + 8'h01;
      enablePwm <= (phaseCnt < (pwmPeriod >> 1));
    end else begin
      phaseCnt <= 8'h00;
      enablePwm <= 1'b1;
    end
  end
endmodule
